// [sim/interrupt_source_map_test.sv]
// self-checking bench of the interrupt source map
// assumes isrc_top, isrc_core_model and one 40 MHz clock
`timescale 1ns/10ps
module interrupt_source_map_test;
   import isrc_pkg::*;
   logic              clk      = 1'b0;
   logic              rstn     = 1'b0;
   logic              wb_cyc   = 1'b0;
   logic              wb_stb   = 1'b0;
   logic              wb_we    = 1'b0;
   logic [ADR_W-1:0]  wb_adr   = '0;
   logic [3:0]        wb_sel   = 4'h0;
   logic [31:0]       wb_dat_w = 32'h0;
   logic [31:0]       wb_dat_r, rd;
   logic              wb_ack, core_req, soft_nmi, irq;
   logic [NSRC-1:0]   src_req  = '0;
   logic              hs       = 1'b0;
   logic              vs       = 1'b0;
   logic [7:0]        core_irq_num, taken_num;
   logic [17:0]       core_offset, taken_off;
   logic [2:0]        core_level;
   int                nmi_count;
   int                bad_count  = 0;
   int                num_checks = 0;
   int irq_tab [21] = '{24,25,27,28,31,32,33,35,36,41,43,44,51,115,117,118,127,128,129,130,131};
   bit per_tab [21] = '{0,1,0,0,0,0,1,0,0,1,0,1,1,1,1,1,1,1,1,0,0};

   always #12.5 clk = ~clk;

   isrc_top isrc_top_inst (.clk(clk), .rstn(rstn), .ce(1'b1), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .src_req(src_req),
      .disp_hsync(hs), .disp_vsync(vs), .core_req(core_req),
      .core_irq_num(core_irq_num), .core_offset(core_offset), .core_level(core_level),
      .soft_nmi(soft_nmi), .irq(irq));
   isrc_core_model isrc_core_model_inst (.clk(clk), .rstn(rstn), .core_req(core_req),
      .core_irq_num(core_irq_num), .core_offset(core_offset), .soft_nmi(soft_nmi),
      .nmi_count(nmi_count), .taken_num(taken_num), .taken_off(taken_off));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (bad_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask

   // one classic cycle; ack and data sampled at the same edge
   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we;
      wb_adr <= a; wb_sel <= s; wb_dat_w <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 16);
      rd = wb_dat_r;
      wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
      if (n >= 16) begin
         bad_count++;
         wrap_up();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      wb(1'b1, a, d, s);
   endtask

   task automatic rdr(input logic [11:0] a);
      wb(1'b0, a, 32'h0, 4'hF);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_regs;
      rdr(A_CTRL); chk("ctrl reset", 32'h0, rd);
      wr(12'h0FC, 32'hFFFF_FFFF, 4'hF);
      rdr(12'h0FC); chk("unmapped", 32'h0, rd);
   endtask

   task automatic t_key;
      wr(A_EVMSK, 32'h0000_0001, 4'hF);
      wr(A_CTRL, 32'h4DFF_0000, 4'hF);
      repeat (3) @(posedge clk);
      chk("wrong key nmi", 0, nmi_count);
      wr(A_CTRL, 32'h4EFF_0000, 4'hF);
      repeat (3) @(posedge clk);
      chk("key nmi", 1, nmi_count);
      chk("irq set", 1, irq);
      rdr(A_CTRL); chk("key field", 32'h4E00_0000, rd);
      wr(A_EVST, 32'h0000_0001, 4'hF);
      repeat (2) @(posedge clk);
      chk("irq clear", 0, irq);
      wr(A_CTRL, 32'h0, 4'hF);
   endtask

   // request held, flag cleared: only persistent ones come back
   task automatic t_map;
      int n, i;
      logic [11:0] fa;
      logic [31:0] b;
      for (int k = 0; k < 21; k++) begin
         n = irq_tab[k];
         i = (n < 52) ? n - 23 : n - 81;
         fa = A_FLAG + 12'(4 * (n >> 5));
         b = 32'h1 << (n % 32);
         @(posedge clk);
         src_req[i] <= 1'b1;
         repeat (3) @(posedge clk);
         rdr(fa); chk("flag bit", b, rd);
         wr(fa, b, 4'hF);
         rdr(fa); chk("persist", per_tab[k] ? b : 32'h0, rd);
         src_req[i] <= 1'b0;
         @(posedge clk);
         wr(fa, 32'hFFFF_FFFF, 4'hF);
      end
   endtask

   task automatic t_vector;
      wr(A_PRI + 12'h030, 32'hFFFF_0DFF, 4'h2); // 49 only, 48 stays off
      wr(A_PRI + 12'h02C, 32'h0E00_0000, 4'h8);
      wr(A_EN + 12'h004, 32'h0003_8000, 4'hF);
      wr(A_VOFF + 12'(4 * 47), 32'h0001_2344, 4'hF);
      wr(A_VOFF + 12'(4 * 49), 32'h0000_0FF1, 4'hF);
      wr(A_CTRL, 32'h0000_1000, 4'h2);
      @(posedge clk);
      src_req[26:24] <= 3'b111;
      repeat (5) @(posedge clk);
      chk("pick sub", 32'd47, core_irq_num);
      chk("multi_vector_select off", 32'h12344, core_offset);
      chk("level", 32'd3, core_level);
      chk("taken", 32'd47, taken_num);
      chk("taken off", 32'h12344, taken_off);
      rdr(A_EVST); chk("pick event", 32'h2, rd);
      wr(A_PRI + 12'h030, 32'h0000_1500, 4'h2);
      repeat (3) @(posedge clk);
      chk("pick pri", 32'd49, core_irq_num);
      chk("off 49", 32'h00FF0, core_offset);
      wr(A_SOFF, 32'h0000_0ABD, 4'hF);
      wr(A_CTRL, 32'h0, 4'h2);
      repeat (3) @(posedge clk);
      chk("single vec", 32'h00ABC, core_offset);
      src_req[26:24] <= 3'b000;
      wr(A_EN + 12'h004, 32'h0, 4'hF);
      wr(A_FLAG + 12'h004, 32'hFFFF_FFFF, 4'hF);
      repeat (3) @(posedge clk);
      chk("idle req", 0, core_req);
      wr(A_EVST, 32'h0000_0007, 4'hF);
   endtask

   task automatic t_display;
      @(posedge clk);
      hs <= 1'b1; vs <= 1'b1;
      repeat (3) @(posedge clk);
      wr(A_DISP, 32'h0000_0003, 4'hF);
      rdr(A_DISP); chk("sync persist", 32'h0000_0003, rd);
      wr(A_DISP, 32'h0000_0100, 4'hF);
      rdr(A_EVST); chk("disp event", 32'h4, rd);
      wr(A_DISP, 32'h8000_0003, 4'hF);
      wr(A_DISP, 32'h8000_0003, 4'hF);
      rdr(A_DISP); chk("sync edge", 32'h8000_0000, rd);
      hs <= 1'b0; vs <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset_regs();
      t_key();
      t_map();
      t_vector();
      t_display();
      wrap_up();
   end
endmodule // interrupt_source_map_test

// [sim/isrc_core_model.sv]
// core side model: takes the picked vector and counts soft nmi pulses
// assumes isrc_top outputs registered on clk, reset synchronous
`timescale 1ns/10ps
module isrc_core_model (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        core_req,
   input  wire logic [7:0]  core_irq_num,
   input  wire logic [17:0] core_offset,
   input  wire logic        soft_nmi,
   output int               nmi_count,
   output logic      [7:0]  taken_num,
   output logic      [17:0] taken_off
);
   always_ff @(posedge clk) begin
      if (!rstn) begin
         nmi_count <= 0;
         taken_num <= 8'h00;
         taken_off <= 18'h00000;
      end else begin
         if (soft_nmi === 1'b1)
            nmi_count <= nmi_count + 1;
         if (core_req === 1'b1) begin
            taken_num <= core_irq_num;
            taken_off <= core_offset;
         end
      end
   end
endmodule // isrc_core_model

// [src/isrc_arbiter.sv]
// picks the pending source of highest priority and forms its vector
// assumes pending already gated by enables; priority 0 means source off
`timescale 1ns/10ps
module isrc_arbiter (
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire logic                                  ce,
   input  wire logic [isrc_pkg::NSRC-1:0]             pend,
   input  wire logic [isrc_pkg::NSRC-1:0][2:0]        pri,
   input  wire logic [isrc_pkg::NSRC-1:0][1:0]        sub,
   input  wire logic [isrc_pkg::NSRC-1:0][16:0]       off,
   input  wire logic                                  multi_vector_select,
   input  wire logic [16:0]                           soft_off,
   output logic                                       valid,
   output logic      [7:0]                            irq_num,
   output logic      [17:0]                           offset,
   output logic      [2:0]                            level,
   output logic                                       new_pick
);
   import isrc_pkg::*;

   logic        found;
   logic [4:0]  best_key;
   logic [5:0]  best;
   logic        next_valid;
   logic [7:0]  next_num;
   logic [17:0] next_off;
   logic [2:0]  next_level;
   logic        next_new;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      found    = 1'b0;
      best_key = '0;
      best     = '0;
      // ties keep the lower request number
      for (int i = 0; i < NSRC; i++) begin
         if (pend[i] && pri[i] != 3'h0 && (!found || {pri[i], sub[i]} > best_key)) begin
            found    = 1'b1;
            best_key = {pri[i], sub[i]};
            best     = 6'(i);
         end
      end
      next_valid = found;
      next_num   = found ? src_irq(int'(best)) : 8'h00;
      next_level = best_key[4:2];
      next_off   = multi_vector_select ? {off[best], 1'b0} : {soft_off, 1'b0};
      next_new   = found && (!valid || next_num != irq_num);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         valid    <= 1'b0;
         irq_num  <= '0;
         offset   <= '0;
         level    <= '0;
         new_pick <= 1'b0;
      end else if (ce) begin
         valid    <= next_valid;
         irq_num  <= next_num;
         offset   <= next_off;
         level    <= next_level;
         new_pick <= next_new;
      end
   end

   single_vec_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && !multi_vector_select && found |=> offset == {$past(soft_off), 1'b0})
      else $error("single vector mode gave a per-source offset");
endmodule // isrc_arbiter

// [src/isrc_flag_bank.sv]
// bank of interrupt flags with per-source persistence
// assumes requests synchronous to clk; clr is a one-cycle software clear
`timescale 1ns/10ps
module isrc_flag_bank #(
   parameter int N = 2
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic [N-1:0] req,
   input  wire logic [N-1:0] persist,
   input  wire logic [N-1:0] clr,
   output logic      [N-1:0] flag
);
   import isrc_pkg::*;

   logic [N-1:0] prev;
   logic [N-1:0] next_prev;
   logic [N-1:0] next_flag;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_prev = req;
      // level or edge set, set beats clear
      next_flag = (persist & req) | (~persist & req & ~prev) | (flag & ~clr);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         prev <= '0;
         flag <= '0;
      end else if (ce) begin
         prev <= next_prev;
         flag <= next_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   genvar g;
   for (g = 0; g < N; g++) begin : g_chk
      persist_hold_a: assert property (@(posedge clk) disable iff (!rstn)
         ce && persist[g] && req[g] && clr[g] |=> flag[g])
         else $error("persistent flag lost while request active");
      edge_once_a: assert property (@(posedge clk) disable iff (!rstn)
         ce && !persist[g] && req[g] && prev[g] && !flag[g] |=> !flag[g])
         else $error("edge flag set again without new event");
   end
endmodule // isrc_flag_bank

// [src/isrc_pkg.sv]
// constants, address map and source tables of the interrupt source map
// assumes one 40 MHz system clock and a classic wishbone master
// Operation
// - timer5, capture5 error, capture5, compare5 sit at requests 24..27; captures persistent
// - timer6 channel sources sit at requests 28..31, word a bits 28..31
// - request 32 wraps to bit 0 of word b; channel 7 follows at 33..35
// - channels 8 and 9 take requests 36..43; capture error and capture persistent
// - converter sources sit at requests 44..51, word b bits 12..19, all persistent
// - priority is 3 bits, subpriority 2 bits, four sources per priority word
// - each request number owns a vector offset entry, bits 17..1 used
// - port change sources A..K without I sit at 118..127, all persistent
// - two-wire unit events sit at 115..117, all persistent
// - parallel host port 128..129 persistent; comparators 130..131 not persistent
// - display sync sources persistent after reset; display register bit 31 makes them edge type
// - control key field bits 31..24 read/write, reset zero; bits 23..16 read zero
// - writing the exact key raises a soft non-maskable interrupt and its status
// - multi-vector select chooses per-source offset or one shared vector
package isrc_pkg;
   localparam int NSRC    = 58;
   localparam int LO_BASE = 23;
   localparam int LO_CNT  = 29;
   localparam int HI_BASE = 110;
   localparam int ADR_W   = 12;

   localparam logic [ADR_W-1:0] A_CTRL  = 12'h000;
   localparam logic [ADR_W-1:0] A_DISP  = 12'h004;
   localparam logic [ADR_W-1:0] A_EVST  = 12'h008;
   localparam logic [ADR_W-1:0] A_EVMSK = 12'h00C;
   localparam logic [ADR_W-1:0] A_SOFF  = 12'h010;
   localparam logic [ADR_W-1:0] A_FLAG  = 12'h020;
   localparam logic [ADR_W-1:0] A_EN    = 12'h040;
   localparam logic [ADR_W-1:0] A_PRI   = 12'h100;
   localparam logic [ADR_W-1:0] A_VOFF  = 12'h400;

   localparam logic [7:0] NMI_KEY     = 8'h4E;
   localparam int         KEY_LSB     = 24;
   localparam int         MULTI_VECTOR_SELECT_BIT    = 12;
   localparam int         DISP_NP_BIT = 31;
   localparam int         DISP_EN_LSB = 8;
   localparam int         PRI_LSB     = 2;
   localparam int         LANE_W      = 8;
   localparam int         OFF_LSB     = 1;
   localparam int         OFF_W       = 17;
   localparam int         EV_NMI      = 0;
   localparam int         EV_PICK     = 1;
   localparam int         EV_DISP     = 2;
   localparam int         EV_W        = 3;

   function automatic logic [7:0] src_irq(input int i);
      return (i < LO_CNT) ? 8'(LO_BASE + i) : 8'(HI_BASE + i - LO_CNT);
   endfunction

   function automatic logic is_persist(input logic [7:0] irq);
      case (irq)
         8'h17, 8'h18, 8'h1B, 8'h1C, 8'h1F, 8'h20, 8'h23, 8'h24,
         8'h27, 8'h28, 8'h2B, 8'h82, 8'h83, 8'h86, 8'h87, 8'h88,
         8'h89, 8'h8A: return 1'b0;
         default:      return 1'b1;
      endcase
   endfunction

   function automatic logic [31:0] wmask(input logic [3:0] sel);
      return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   function automatic logic [ADR_W-1:0] word_adr(input logic [ADR_W-1:0] base,
                                                 input int n);
      return base + ADR_W'(n * 4);
   endfunction
endpackage

// [src/isrc_top.sv]
// interrupt source map: flags, enables, priorities, vector offsets, soft nmi
// assumes classic wishbone master on clk; requests synchronous to clk
`timescale 1ns/10ps
module isrc_top (
   input  wire logic                            clk,
   input  wire logic                            rstn,
   input  wire logic                            ce,
   input  wire logic                            wb_cyc,
   input  wire logic                            wb_stb,
   input  wire logic                            wb_we,
   input  wire logic [isrc_pkg::ADR_W-1:0]      wb_adr,
   input  wire logic [3:0]                      wb_sel,
   input  wire logic [31:0]                     wb_dat_w,
   output logic      [31:0]                     wb_dat_r,
   output logic                                 wb_ack,
   input  wire logic [isrc_pkg::NSRC-1:0]       src_req,
   input  wire logic                            disp_hsync,
   input  wire logic                            disp_vsync,
   output logic                                 core_req,
   output logic      [7:0]                      core_irq_num,
   output logic      [17:0]                     core_offset,
   output logic      [2:0]                      core_level,
   output logic                                 soft_nmi,
   output logic                                 irq
);
   import isrc_pkg::*;

   logic [7:0]                  key;
   logic                        multi_vector_select;
   logic                        disp_np;
   logic [1:0]                  disp_en;
   logic [EV_W-1:0]             ev;
   logic [EV_W-1:0]             ev_mask;
   logic [16:0]                 soft_off;
   logic [NSRC-1:0]             en;
   logic [NSRC-1:0][2:0]        pri;
   logic [NSRC-1:0][1:0]        sub;
   logic [NSRC-1:0][16:0]       off;
   logic [NSRC-1:0]             flag;
   logic [1:0]                  disp_flag;
   logic                        pick;

   logic [7:0]                  next_key;
   logic                        next_multi_vector_select;
   logic                        next_disp_np;
   logic [1:0]                  next_disp_en;
   logic [EV_W-1:0]             next_ev;
   logic [EV_W-1:0]             next_ev_mask;
   logic [16:0]                 next_soft_off;
   logic [NSRC-1:0]             next_en;
   logic [NSRC-1:0][2:0]        next_pri;
   logic [NSRC-1:0][1:0]        next_sub;
   logic [NSRC-1:0][16:0]       next_off;
   logic                        next_ack;
   logic [31:0]                 next_dat;
   logic                        next_nmi;
   logic                        next_irq;

   logic [NSRC-1:0]             clr;
   logic [1:0]                  disp_clr;
   logic [NSRC-1:0]             persist;
   logic                        wr;
   logic [31:0]                 wm;
   logic [31:0]                 wd;
   logic [EV_W-1:0]             ev_set;
   logic                        key_hit;

   ////////////////////////////////////////////////////////////////////////////////
   genvar g;
   for (g = 0; g < NSRC; g++) begin : g_persist
      assign persist[g] = is_persist(src_irq(g));
   end

   isrc_flag_bank #(.N(NSRC)) u_src_flags (
      .clk     (clk),
      .rstn    (rstn),
      .ce      (ce),
      .req     (src_req),
      .persist (persist),
      .clr     (clr),
      .flag    (flag)
   );

   // display syncs level type until switched to edge type
   isrc_flag_bank #(.N(2)) u_disp_flags (
      .clk     (clk),
      .rstn    (rstn),
      .ce      (ce),
      .req     ({disp_vsync, disp_hsync}),
      .persist ({2{~disp_np}}),
      .clr     (disp_clr),
      .flag    (disp_flag)
   );

   isrc_arbiter u_arb (
      .clk      (clk),
      .rstn     (rstn),
      .ce       (ce),
      .pend     (flag & en),
      .pri      (pri),
      .sub      (sub),
      .off      (off),
      .multi_vector_select     (multi_vector_select),
      .soft_off (soft_off),
      .valid    (core_req),
      .irq_num  (core_irq_num),
      .offset   (core_offset),
      .level    (core_level),
      .new_pick (pick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // write happens on the edge where ack is seen, so the master holds data there
   always_comb begin
      wr            = wb_cyc && wb_stb && wb_we && wb_ack;
      wm            = wmask(wb_sel);
      wd            = wb_dat_w & wm;
      next_ack      = wb_cyc && wb_stb && !wb_ack;
      next_key      = key;
      next_multi_vector_select     = multi_vector_select;
      next_disp_np  = disp_np;
      next_disp_en  = disp_en;
      next_ev_mask  = ev_mask;
      next_soft_off = soft_off;
      next_en       = en;
      next_pri      = pri;
      next_sub      = sub;
      next_off      = off;
      clr           = '0;
      disp_clr      = '0;
      key_hit       = 1'b0;
      ev_set        = '0;
      if (wr && wb_adr == A_CTRL) begin
         if (wb_sel[3]) begin
            next_key = wb_dat_w[KEY_LSB +: 8];
            key_hit  = (wb_dat_w[KEY_LSB +: 8] == NMI_KEY);
         end
         if (wm[MULTI_VECTOR_SELECT_BIT])
            next_multi_vector_select = wb_dat_w[MULTI_VECTOR_SELECT_BIT];
      end
      if (wr && wb_adr == A_DISP) begin
         if (wm[DISP_NP_BIT])
            next_disp_np = wb_dat_w[DISP_NP_BIT];
         if (wm[DISP_EN_LSB])
            next_disp_en = wb_dat_w[DISP_EN_LSB +: 2];
         disp_clr = wd[1:0];
      end
      if (wr && wb_adr == A_EVMSK && wb_sel[0])
         next_ev_mask = wb_dat_w[EV_W-1:0];
      if (wr && wb_adr == A_SOFF)
         next_soft_off = (soft_off & ~wm[OFF_LSB +: OFF_W]) | wd[OFF_LSB +: OFF_W];
      for (int i = 0; i < NSRC; i++) begin
         automatic logic [7:0] n = src_irq(i);
         automatic int lane = int'(n[1:0]) * LANE_W;
         if (wr && wb_adr == word_adr(A_FLAG, int'(n[7:5])))
            clr[i] = wd[n[4:0]];
         if (wr && wb_adr == word_adr(A_EN, int'(n[7:5])) && wm[n[4:0]])
            next_en[i] = wb_dat_w[n[4:0]];
         // four byte lanes per priority word
         if (wr && wb_adr == word_adr(A_PRI, int'(n[7:2])) && wm[lane]) begin
            next_pri[i] = wb_dat_w[lane + PRI_LSB +: 3];
            next_sub[i] = wb_dat_w[lane +: 2];
         end
         // one offset entry per request number
         if (wr && wb_adr == word_adr(A_VOFF, int'(n)))
            next_off[i] = (off[i] & ~wm[OFF_LSB +: OFF_W]) | wd[OFF_LSB +: OFF_W];
      end
      ev_set[EV_NMI]  = key_hit;
      ev_set[EV_PICK] = pick;
      ev_set[EV_DISP] = |(disp_flag & disp_en);
      // sticky events, set beats write-one clear
      next_ev = ev_set | (ev & ~((wr && wb_adr == A_EVST) ? wd[EV_W-1:0] : '0));
      next_nmi = key_hit;
      next_irq = |(next_ev & next_ev_mask);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data captured with ack; unmapped words read zero and still ack
   always_comb begin
      next_dat = '0;
      case (wb_adr)
         A_CTRL: begin
            next_dat[KEY_LSB +: 8] = key;
            next_dat[MULTI_VECTOR_SELECT_BIT]     = multi_vector_select;
         end
         A_DISP: begin
            next_dat[DISP_NP_BIT]        = disp_np;
            next_dat[DISP_EN_LSB +: 2]   = disp_en;
            next_dat[1:0]                = disp_flag;
         end
         A_EVST:  next_dat[EV_W-1:0] = ev;
         A_EVMSK: next_dat[EV_W-1:0] = ev_mask;
         A_SOFF:  next_dat[OFF_LSB +: OFF_W] = soft_off;
         default: begin
            for (int i = 0; i < NSRC; i++) begin
               automatic logic [7:0] n = src_irq(i);
               automatic int lane = int'(n[1:0]) * LANE_W;
               if (wb_adr == word_adr(A_FLAG, int'(n[7:5])))
                  next_dat[n[4:0]] = flag[i];
               if (wb_adr == word_adr(A_EN, int'(n[7:5])))
                  next_dat[n[4:0]] = en[i];
               if (wb_adr == word_adr(A_PRI, int'(n[7:2])))
                  next_dat[lane +: 5] = {pri[i], sub[i]};
               if (wb_adr == word_adr(A_VOFF, int'(n)))
                  next_dat[OFF_LSB +: OFF_W] = off[i];
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         key      <= '0;
         multi_vector_select     <= 1'b0;
         disp_np  <= 1'b0;
         disp_en  <= '0;
         ev       <= '0;
         ev_mask  <= '0;
         soft_off <= '0;
         en       <= '0;
         pri      <= '0;
         sub      <= '0;
         off      <= '0;
         wb_ack   <= 1'b0;
         wb_dat_r <= '0;
         soft_nmi <= 1'b0;
         irq      <= 1'b0;
      end else if (ce) begin
         key      <= next_key;
         multi_vector_select     <= next_multi_vector_select;
         disp_np  <= next_disp_np;
         disp_en  <= next_disp_en;
         ev       <= next_ev;
         ev_mask  <= next_ev_mask;
         soft_off <= next_soft_off;
         en       <= next_en;
         pri      <= next_pri;
         sub      <= next_sub;
         off      <= next_off;
         wb_ack   <= next_ack;
         wb_dat_r <= next_ack ? next_dat : '0;
         soft_nmi <= next_nmi;
         irq      <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   nmi_key_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && wr && wb_adr == A_CTRL && wb_sel[3] && wb_dat_w[31:24] == NMI_KEY
      |=> soft_nmi && ev[EV_NMI])
      else $error("key write did not raise soft nmi");
   key_other_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && !(wr && wb_adr == A_CTRL && wb_sel[3] && wb_dat_w[31:24] == NMI_KEY)
      |=> !soft_nmi)
      else $error("soft nmi without key");
   ctrl_zero_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && wb_cyc && wb_stb && !wb_ack && wb_adr == A_CTRL
      |=> wb_dat_r[23:16] == 8'h00 && wb_dat_r[31:24] == $past(key))
      else $error("control read shows wrong key or reserved bits");
   ack_time_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
      else $error("ack not a single cycle after request");
   disp_persist_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && !disp_np && disp_hsync && disp_clr[0] |=> disp_flag[0])
      else $error("display sync not persistent");
   irq_level_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && |(ev & ev_mask) && !(wr && wb_adr == A_EVST) && !(wr && wb_adr == A_EVMSK)
      |=> irq)
      else $error("interrupt line low with unmasked event");

   nmi_c:  cover property (@(posedge clk) disable iff (!rstn) soft_nmi);
   pick_c: cover property (@(posedge clk) disable iff (!rstn) core_req && multi_vector_select);
   disp_c: cover property (@(posedge clk) disable iff (!rstn) disp_np && disp_flag[1]);
endmodule // isrc_top
